/* core/gpibl_pkg.sv */
`default_nettype none
package gpibl_pkg;

   // register byte addresses
   localparam logic [7:0] ADDR_CPT   = 8'h00;
   localparam logic [7:0] ADDR_DIN   = 8'h04;
   localparam logic [7:0] ADDR_EOS   = 8'h08;
   localparam logic [7:0] ADDR_AUX   = 8'h0C;
   localparam logic [7:0] ADDR_CNT2  = 8'h10;
   localparam logic [7:0] ADDR_CTRL  = 8'h14;
   localparam logic [7:0] ADDR_ISR   = 8'h18;
   localparam logic [7:0] ADDR_IMR   = 8'h1C;
   localparam logic [7:0] ADDR_DOUT  = 8'h20;

   // shared offset routing by upper nibble
   localparam logic [3:0] ICR_TAG    = 4'h2;
   localparam logic [3:0] AUX_TAG    = 4'h0;
   localparam logic [7:0] ICR_RESET  = 8'h25;

   // handshake mode field of the auxiliary command
   localparam logic [1:0] HS_NORMAL  = 2'h0;
   localparam logic [1:0] HS_CONT    = 2'h3;

   // control register fields
   localparam int         CTRL_LEGACY = 0;
   localparam int         CTRL_DMA_INPUT_ENABLE   = 1;
   localparam int         CTRL_BIN    = 2;
   localparam int         CTRL_RECEIVE_EOS_ENABLE   = 3;
   localparam int         CTRL_TRANSMIT_EOS_ENABLE   = 4;
   localparam int         CTRL_W      = 5;
   localparam logic [4:0] CTRL_RESET  = 5'h00;

   // interrupt status fields and CNT2 clock multiplier bit
   localparam int         ISR_DI      = 0;
   localparam int         ISR_END     = 1;
   localparam int         ISR_W       = 2;
   localparam int         CNT2_CLOCK_MULTIPLIER_BIT   = 0;

   // source settling delay
   localparam int         T1_NS       = 2000;
   localparam int         NS_PER_US   = 1000;

   typedef enum logic [2:0] {
      TS_IDLE   = 3'b001,
      TS_SETTLE = 3'b010,
      TS_VALID  = 3'b100
   } gpibl_talk_e;

   function automatic logic [7:0] dly_cycles(input logic [3:0] f, input logic m);
      logic [4:0] mhz;
      logic [7:0] c;
      mhz = m ? {f, 1'b0} : {1'b0, f};
      c   = 8'(int'(mhz) * T1_NS / NS_PER_US);
      if (c == 8'h00) begin
         c = 8'h01;
      end
      return c;
   endfunction : dly_cycles

   function automatic logic eos_match(input logic [7:0] b, input logic [7:0] e,
                                      input logic binary_compare_select);
      return binary_compare_select ? (b == e) : (b[6:0] == e[6:0]);
   endfunction : eos_match

endpackage : gpibl_pkg
`default_nettype wire

/* core/gpibl_settle_timer.sv */
`default_nettype none
module gpibl_settle_timer
   import gpibl_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       srst,
   input  wire logic       start,
   input  wire logic [3:0] freq_field,
   input  wire logic       mult,
   output logic            busy,
   output logic            done
);

   typedef struct packed {
      logic [7:0] cnt;
      logic       busy;
      logic       done;
   } gpibl_tmr_s;

   gpibl_tmr_s s_r;
   gpibl_tmr_s s_nxt;

   // down counter scaled by programmed clock frequency
   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      if (start) begin
         s_nxt.cnt  = dly_cycles(freq_field, mult); // [R13]
         s_nxt.busy = 1'b1;
      end else if (s_r.busy) begin
         if (s_r.cnt == 8'h01) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = s_r.busy;
   assign done = s_r.done;

endmodule : gpibl_settle_timer
`default_nettype wire

/* core/gpibl_regs.sv */
// Summary of operation
// [R1] read-only view shows live data lines for inspecting a command byte
// [R2] host reads that view only during an accept holdoff
// [R3] addressed listener in accept state latches data lines into data-in
// [R4] latching sets data-input flag in status bit 0 unless continuous mode
// [R5] latching normally holds off ready-for-data until the byte is read
// [R6] data-in read clears flag, drops dma request when dma input enabled, releases holdoff
// [R7] outgoing data write leaves data-in contents unchanged
// [R8] end-of-string compare uses 7 or 8 bits per binary select
// [R9] listener with receive compare sets end flag on matching byte
// [R10] talker with transmit compare drives eoi low with matching byte
// [R11] clock frequency register is write-only, shares auxiliary offset
// [R12] clock frequency register resets to the 5 MHz setting
// [R13] bus delays timed from frequency field and multiplier bit
// [R14] host programs frequency field and multiplier to match clock
// [R15] these registers decode only in legacy register mode
// [R16] host writes 0010 in upper nibble to reach clock register
`default_nettype none
module gpibl_regs
   import gpibl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  gpib_dio_in,
   input  wire logic        listener_active,
   input  wire logic        acceptor_accept,
   input  wire logic        talker_active,
   input  wire logic        talk_accepted,
   output logic [7:0]       talk_data,
   output logic             talk_eoi_n,
   output logic             talk_data_valid,
   output logic             rfd_holdoff,
   output logic             dma_request_n,
   output logic             irq
);

   typedef struct packed {
      logic [7:0]      din;
      logic [7:0]      eos;
      logic [7:0]      clock_frequency_select;
      logic            clock_multiplier_bit;
      logic [1:0]      hs_mode;
      logic [4:0]      ctrl;
      logic [1:0]      isr;
      logic [1:0]      imr;
      logic [7:0]      dout;
      logic            eoi_n;
      gpibl_talk_e     tstate;
      logic            rfd_hold;
      logic            dreq_n;
      logic            acc_prev;
      logic            irq;
      logic [31:0]     prdata;
   } gpibl_regs_s;

   gpibl_regs_s s_r;
   gpibl_regs_s s_nxt;

   logic legacy;
   logic access;
   logic wr;
   logic rd;
   logic cap;
   logic cont_mode;
   logic dout_take;
   logic settle_busy;
   logic settle_done;

   function automatic logic reg_mapped(input logic [7:0] a, input logic leg);
      logic m;
      m = 1'b0;
      if (a == ADDR_CTRL) begin
         m = 1'b1;
      end else if (a == ADDR_CPT || a == ADDR_DIN || a == ADDR_EOS) begin
         m = leg; // [R15]
      end else if (a == ADDR_AUX || a == ADDR_CNT2 || a == ADDR_DOUT) begin
         m = leg;
      end else if (a == ADDR_ISR || a == ADDR_IMR) begin
         m = leg;
      end
      return m;
   endfunction : reg_mapped

   assign legacy    = s_r.ctrl[CTRL_LEGACY];
   assign access    = psel && penable && reg_mapped(paddr, legacy);
   assign wr        = access && pwrite && pstrb[0];
   assign rd        = access && !pwrite;
   assign cont_mode = (s_r.hs_mode == HS_CONT);
   // rising edge of accept state while addressed
   assign cap       = listener_active && acceptor_accept && !s_r.acc_prev; // [R3]
   assign dout_take = wr && (paddr == ADDR_DOUT) && (s_r.tstate == TS_IDLE);

   gpibl_settle_timer u_settle (
      .mclk       (mclk),
      .srst       (srst),
      .start      (dout_take),
      .freq_field (s_r.clock_frequency_select[3:0]),
      .mult       (s_r.clock_multiplier_bit),
      .busy       (settle_busy),
      .done       (settle_done)
   );

   always_comb begin
      s_nxt          = s_r;
      s_nxt.acc_prev = listener_active && acceptor_accept;

      // read data staged in setup phase
      if (psel && !penable && !pwrite) begin
         s_nxt.prdata = 32'h0000_0000;
         if (!reg_mapped(paddr, legacy)) begin
            s_nxt.prdata = 32'h0000_0000;
         end else if (paddr == ADDR_CPT) begin
            s_nxt.prdata = {24'h00_0000, gpib_dio_in}; // [R1]
         end else if (paddr == ADDR_DIN) begin
            s_nxt.prdata = {24'h00_0000, s_r.din};
         end else if (paddr == ADDR_CTRL) begin
            s_nxt.prdata = {27'h000_0000, s_r.ctrl};
         end else if (paddr == ADDR_ISR) begin
            s_nxt.prdata = {30'h0000_0000, s_r.isr};
         end else if (paddr == ADDR_IMR) begin
            s_nxt.prdata = {30'h0000_0000, s_r.imr};
         end
      end

      // register writes
      if (wr) begin
         if (paddr == ADDR_EOS) begin
            s_nxt.eos = pwdata[7:0];
         end else if (paddr == ADDR_AUX) begin
            if (pwdata[7:4] == ICR_TAG) begin
               s_nxt.clock_frequency_select = pwdata[7:0]; // [R11] [R16]
            end else if (pwdata[7:4] == AUX_TAG) begin
               s_nxt.hs_mode = pwdata[1:0];
            end
         end else if (paddr == ADDR_CNT2) begin
            s_nxt.clock_multiplier_bit = pwdata[CNT2_CLOCK_MULTIPLIER_BIT];
         end else if (paddr == ADDR_CTRL) begin
            s_nxt.ctrl = pwdata[CTRL_W-1:0];
         end else if (paddr == ADDR_IMR) begin
            s_nxt.imr = pwdata[ISR_W-1:0];
         end
      end

      // read side effects
      if (rd && paddr == ADDR_ISR) begin
         s_nxt.isr = '0;
      end
      if (rd && paddr == ADDR_DIN) begin
         s_nxt.isr[ISR_DI] = 1'b0; // [R6]
         s_nxt.rfd_hold    = 1'b0; // [R6]
         if (s_r.ctrl[CTRL_DMA_INPUT_ENABLE]) begin
            s_nxt.dreq_n = 1'b1; // [R6]
         end
      end

      // listener capture, set wins over clear
      if (cap) begin
         s_nxt.din = gpib_dio_in; // [R3] [R7]
         if (!cont_mode) begin
            s_nxt.isr[ISR_DI] = 1'b1; // [R4]
            s_nxt.rfd_hold    = 1'b1; // [R5]
            if (s_r.ctrl[CTRL_DMA_INPUT_ENABLE]) begin
               s_nxt.dreq_n = 1'b0;
            end
         end
         if (s_r.ctrl[CTRL_RECEIVE_EOS_ENABLE] && eos_match(gpib_dio_in, s_r.eos, s_r.ctrl[CTRL_BIN])) begin
            s_nxt.isr[ISR_END] = 1'b1; // [R8] [R9]
         end
      end

      // talker output sequence
      case (s_r.tstate)
         TS_IDLE: begin
            if (dout_take) begin
               s_nxt.dout   = pwdata[7:0]; // [R7]
               s_nxt.eoi_n  = !(talker_active && s_r.ctrl[CTRL_TRANSMIT_EOS_ENABLE]
                                && eos_match(pwdata[7:0], s_r.eos,
                                             s_r.ctrl[CTRL_BIN])); // [R8] [R10]
               s_nxt.tstate = TS_SETTLE;
            end
         end
         TS_SETTLE: begin
            if (settle_done) begin
               s_nxt.tstate = TS_VALID; // [R13]
            end
         end
         TS_VALID: begin
            if (talk_accepted) begin
               s_nxt.tstate = TS_IDLE;
               s_nxt.eoi_n  = 1'b1;
            end
         end
         default: begin
            s_nxt.tstate = TS_IDLE;
         end
      endcase

      s_nxt.irq = |(s_nxt.isr & s_nxt.imr);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         s_r          <= '0;
         s_r.clock_frequency_select      <= ICR_RESET; // [R12]
         s_r.hs_mode  <= HS_NORMAL;
         s_r.ctrl     <= CTRL_RESET;
         s_r.eoi_n    <= 1'b1;
         s_r.dreq_n   <= 1'b1;
         s_r.tstate   <= TS_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata          = s_r.prdata;
   assign pready          = 1'b1;
   assign pslverr         = psel && penable && !reg_mapped(paddr, legacy);
   assign talk_data       = s_r.dout;
   assign talk_eoi_n      = s_r.eoi_n;
   assign talk_data_valid = (s_r.tstate == TS_VALID);
   assign rfd_holdoff     = s_r.rfd_hold;
   assign dma_request_n   = s_r.dreq_n;
   assign irq             = s_r.irq;

   AST_PASSTHRU: assert property (@(posedge mclk) disable iff (srst) // [R1]
      psel && !penable && !pwrite && legacy && paddr == ADDR_CPT
      |=> prdata == {24'h00_0000, $past(gpib_dio_in)})
      else $error("passthrough view does not show data lines");

   AST_CAPTURE: assert property (@(posedge mclk) disable iff (srst) // [R3]
      cap |=> s_r.din == $past(gpib_dio_in))
      else $error("data-in not latched on accept");

   AST_DI_SET: assert property (@(posedge mclk) disable iff (srst) // [R4]
      cap && !cont_mode |=> s_r.isr[ISR_DI])
      else $error("data-input flag not set on capture");

   AST_HOLDOFF: assert property (@(posedge mclk) disable iff (srst) // [R5]
      cap && !cont_mode ##1 !(rd && paddr == ADDR_DIN) |=> rfd_holdoff)
      else $error("ready-for-data holdoff not kept after capture");

   AST_DIN_READ: assert property (@(posedge mclk) disable iff (srst) // [R6]
      rd && paddr == ADDR_DIN && !cap
      |=> !s_r.isr[ISR_DI] && !rfd_holdoff && (!$past(s_r.ctrl[CTRL_DMA_INPUT_ENABLE]) || dma_request_n))
      else $error("data-in read side effects missing");

   AST_SEPARATE: assert property (@(posedge mclk) disable iff (srst) // [R7]
      wr && paddr == ADDR_DOUT && !cap |=> $stable(s_r.din))
      else $error("outgoing write disturbed data-in");

   AST_END_FLAG: assert property (@(posedge mclk) disable iff (srst) // [R9]
      cap && s_r.ctrl[CTRL_RECEIVE_EOS_ENABLE] && s_r.ctrl[CTRL_BIN] && gpib_dio_in == s_r.eos
      |=> s_r.isr[ISR_END])
      else $error("end flag not set on matching byte");

   AST_EOS7: assert property (@(posedge mclk) disable iff (srst) // [R8]
      cap && s_r.ctrl[CTRL_RECEIVE_EOS_ENABLE] && !s_r.ctrl[CTRL_BIN]
      && gpib_dio_in[6:0] == s_r.eos[6:0] |=> s_r.isr[ISR_END])
      else $error("seven-bit compare missed a match");

   AST_EOI: assert property (@(posedge mclk) disable iff (srst) // [R10]
      dout_take && talker_active && s_r.ctrl[CTRL_TRANSMIT_EOS_ENABLE] && s_r.ctrl[CTRL_BIN]
      && pwdata[7:0] == s_r.eos |=> !talk_eoi_n [*2])
      else $error("eoi not asserted with matching byte");

   AST_ICR_WR: assert property (@(posedge mclk) disable iff (srst) // [R11]
      wr && paddr == ADDR_AUX && pwdata[7:4] == ICR_TAG |=> s_r.clock_frequency_select == $past(pwdata[7:0]))
      else $error("clock register not written at shared offset");

   AST_ICR_RST: assert property (@(posedge mclk) // [R12]
      $fell(srst) |-> s_r.clock_frequency_select == ICR_RESET)
      else $error("clock register reset value wrong");

   AST_SETTLE: assert property (@(posedge mclk) disable iff (srst) // [R13]
      dout_take |=> !talk_data_valid ##[1:64] talk_data_valid)
      else $error("settle delay not completed in time");

   AST_LEGACY: assert property (@(posedge mclk) disable iff (srst) // [R15]
      psel && penable && !legacy && paddr == ADDR_DIN |-> pslverr)
      else $error("data-in decoded outside legacy mode");

   AST_SETTLE_BUSY: assert property (@(posedge mclk) disable iff (srst) // [R13]
      s_r.tstate == TS_SETTLE |-> settle_busy || settle_done)
      else $error("settle state without running delay timer");

   AST_CONT_NOFLAG: assert property (@(posedge mclk) disable iff (srst) // [R4]
      cap && cont_mode && !s_r.isr[ISR_DI] |=> !s_r.isr[ISR_DI])
      else $error("data-input flag set in continuous mode");

   AST_DREQ_SET: assert property (@(posedge mclk) disable iff (srst) // [R6]
      cap && !cont_mode && s_r.ctrl[CTRL_DMA_INPUT_ENABLE] |=> !dma_request_n)
      else $error("dma request not raised on capture");

   AST_AUX_WO: assert property (@(posedge mclk) disable iff (srst) // [R11]
      psel && !penable && !pwrite && legacy && paddr == ADDR_AUX
      |=> prdata == 32'h0000_0000)
      else $error("write-only clock register returned data");

endmodule : gpibl_regs
`default_nettype wire

/* verif/gpibl_far_end.sv */
`default_nettype none
module gpibl_far_end (
   input  wire logic  mclk,
   input  wire logic  talk_data_valid,
   output logic [7:0] gpib_dio_in,
   output logic       acceptor_accept,
   output logic       talk_accepted
);
   timeunit 1ns;
   timeprecision 1ns;
   int slow;
   int cnt;
   initial begin
      slow = 0;
      cnt = 0;
      gpib_dio_in = 8'h00;
      acceptor_accept = 1'b0;
      talk_accepted = 1'b0;
   end
   // byte placed, then accept state entered and held
   task automatic offer(input logic [7:0] b);
      @(posedge mclk);
      gpib_dio_in <= b;
      @(posedge mclk);
      acceptor_accept <= 1'b1;
   endtask : offer
   // accept left; released lines show the inverse
   task automatic drop();
      @(posedge mclk);
      acceptor_accept <= 1'b0;
      gpib_dio_in <= ~gpib_dio_in;
   endtask : drop
   // takes a settled byte after slow cycles
   always @(posedge mclk) begin
      cnt <= (talk_data_valid && !talk_accepted) ? cnt + 1 : 0;
      talk_accepted <= talk_data_valid && !talk_accepted && cnt >= slow;
   end
endmodule : gpibl_far_end
`default_nettype wire

/* verif/gpib_listener_data_eos_clock_regs_tb.sv */
`default_nettype none
module gpib_listener_data_eos_clock_regs_tb
   import gpibl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'hF;
   logic        listener_active = 1'b0;
   logic        talker_active = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  dio;
   logic        accept;
   logic        talk_accepted;
   logic [7:0]  talk_data;
   logic        talk_eoi_n;
   logic        talk_data_valid;
   logic        rfd_holdoff;
   logic        dma_request_n;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   int          n_errors = 0;
   int          checks_done = 0;

   always #25 mclk = ~mclk;

   gpibl_regs uut (.mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gpib_dio_in(dio), .listener_active(listener_active),
      .acceptor_accept(accept), .talker_active(talker_active),
      .talk_accepted(talk_accepted), .talk_data(talk_data), .talk_eoi_n(talk_eoi_n),
      .talk_data_valid(talk_data_valid), .rfd_holdoff(rfd_holdoff),
      .dma_request_n(dma_request_n), .irq(irq));

   gpibl_far_end far (.mclk(mclk), .talk_data_valid(talk_data_valid), .gpib_dio_in(dio),
      .acceptor_accept(accept), .talk_accepted(talk_accepted));

   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; read data and error taken at the ready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   task automatic t_reset();
      apb(1'b0, ADDR_CPT, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b0, ADDR_DIN, 32'h0);
      chk(32'({pready, err}), 32'h3);
      rdchk(ADDR_CTRL, 32'h0);
      chk(32'({talk_eoi_n, dma_request_n, rfd_holdoff, irq}), 32'hC);
      apb(1'b0, 8'h24, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b1, ADDR_CTRL, 32'h1);
   endtask : t_reset

   task automatic t_pass();
      far.offer(8'h3C);
      rdchk(ADDR_CPT, 32'h3C);
      far.drop();
   endtask : t_pass

   task automatic t_capture();
      @(posedge mclk);
      listener_active <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h3);
      apb(1'b1, ADDR_IMR, 32'h1);
      far.offer(8'hA5);
      @(negedge mclk);
      @(negedge mclk);
      chk(32'({rfd_holdoff, dma_request_n, irq}), 32'h5);
      far.drop();
      apb(1'b1, ADDR_DOUT, 32'h5A);
      rdchk(ADDR_DIN, 32'hA5);
      @(negedge mclk);
      chk(32'({rfd_holdoff, dma_request_n}), 32'h1);
      rdchk(ADDR_ISR, 32'h0);
      @(negedge mclk);
      chk(32'(irq), 32'h0);
   endtask : t_capture

   task automatic t_cont();
      apb(1'b1, ADDR_AUX, 32'h3);
      far.offer(8'h77);
      @(negedge mclk);
      @(negedge mclk);
      chk(32'(rfd_holdoff), 32'h0);
      far.drop();
      rdchk(ADDR_ISR, 32'h0);
      rdchk(ADDR_DIN, 32'h77);
      apb(1'b1, ADDR_AUX, 32'h0);
   endtask : t_cont

   task automatic t_eos();
      logic [7:0] b [3] = '{8'h0A, 8'h0A, 8'h8A};
      logic [7:0] c [3] = '{8'h09, 8'h0D, 8'h0D};
      logic [7:0] e [3] = '{8'h03, 8'h01, 8'h03};
      apb(1'b1, ADDR_EOS, 32'h8A);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, ADDR_CTRL, 32'(c[i]));
         far.offer(b[i]);
         far.drop();
         rdchk(ADDR_ISR, 32'(e[i]));
         rdchk(ADDR_DIN, 32'(b[i]));
      end
   endtask : t_eos

   // send one byte; n counts negedges until valid shows
   task automatic tx(input logic [7:0] b, input logic eoi_n, input int n);
      int k;
      apb(1'b1, ADDR_DOUT, 32'(b));
      @(negedge mclk);
      chk(32'({talk_data, talk_eoi_n}), 32'({b, eoi_n}));
      k = 1;
      while (talk_data_valid !== 1'b1 && k < 400) begin
         @(negedge mclk);
         k++;
      end
      chk(32'(k), 32'(n));
      while (talk_data_valid === 1'b1) @(negedge mclk);
      chk(32'(talk_eoi_n), 32'h1);
   endtask : tx

   task automatic t_talk();
      @(posedge mclk);
      talker_active <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h15);
      tx(8'h8A, 1'b0, 12);
      tx(8'h0A, 1'b1, 12);
      apb(1'b1, ADDR_AUX, 32'h2A);
      rdchk(ADDR_AUX, 32'h0);
      apb(1'b1, ADDR_CNT2, 32'h1);
      far.slow = 3;
      tx(8'h8A, 1'b0, 42);
   endtask : t_talk

   // refused writes: busy talker, missing byte strobe
   task automatic t_strb();
      apb(1'b1, ADDR_DOUT, 32'h33);
      apb(1'b1, ADDR_DOUT, 32'h44);
      @(negedge mclk);
      chk(32'(talk_data), 32'h33);
      while (talk_data_valid !== 1'b1) @(negedge mclk);
      while (talk_data_valid === 1'b1) @(negedge mclk);
      @(posedge mclk);
      pstrb <= 4'hE;
      apb(1'b1, ADDR_CTRL, 32'h0);
      pstrb <= 4'hF;
      rdchk(ADDR_CTRL, 32'h15);
   endtask : t_strb

   task automatic t_mask();
      apb(1'b1, ADDR_IMR, 32'h0);
      far.offer(8'h11);
      far.drop();
      @(negedge mclk);
      chk(32'(irq), 32'h0);
      rdchk(ADDR_ISR, 32'h1);
      rdchk(ADDR_DIN, 32'h11);
   endtask : t_mask

   initial begin
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      t_reset();
      t_pass();
      t_capture();
      t_cont();
      t_eos();
      t_talk();
      t_strb();
      t_mask();
      report_and_stop();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      report_and_stop();
   end
endmodule : gpib_listener_data_eos_clock_regs_tb
`default_nettype wire
